// ===== serial_attenuator_control.sv
// three-wire serial control and decoder for a two-channel attenuator
// assumes serial lines are asynchronous; serial clock far slower than clk
//
// Behaviour
// - a word is 16 bits: selection byte then attenuation byte
// - each byte travels most significant bit first
// - selection byte is shifted in completely before attenuation byte
// - selection 00 is channel 1, 01 channel 2, 02 channel 3
// - codes 00-5F give half dB steps, 60-7E one dB steps to 78 dB
// - codes 7F through FF mute the selected channel
// - all channels come up muted without any command
// - mute code overrides any earlier attenuation setting
// - muted channel disconnects input and grounds output through about 2k
// - only a recognised selection code changes a channel
// - data is sampled on each rising serial clock edge while enable is low
// - shifting happens only while enable is low
// - rising edge of enable latches, decodes and updates the channel
// - bit leaving the shift register appears on serial out for chaining
`include "atten_regs.svh"

module serial_attenuator_control
#(
	parameter int WORD_BITS = `WORD_BITS
)
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	// serial control pins
	input  wire logic            ser_clk,
	input  wire logic            ser_en_n,
	input  wire logic            ser_din,
	output logic                 ser_dout,
	// channel controls toward the ladder
	output atten_pkg::level_t    ch1_level,
	output logic                 ch1_mute,
	output atten_pkg::level_t    ch2_level,
	output logic                 ch2_mute,
	// half-dB units of current attenuation, valid when not muted
	output logic [7:0]           ch1_half_db,
	output logic [7:0]           ch2_half_db,
	// one-cycle pulse after each latched word
	output logic                 word_latched
);
	import atten_pkg::*;

	logic sclk_s;
	logic en_n_s;
	logic din_s;

	// equal filter latency on all three lines keeps data aligned with its clock edge
	// filters preset high: an idle-low serial clock only gives a harmless fall after reset
	pin_sync u_sync_clk
	(
		.clk     (clk),
		.reset_n (reset_n),
		.pin     (ser_clk),
		.level   (sclk_s)
	);

	pin_sync u_sync_en
	(
		.clk     (clk),
		.reset_n (reset_n),
		.pin     (ser_en_n),
		.level   (en_n_s)
	);

	pin_sync u_sync_din
	(
		.clk     (clk),
		.reset_n (reset_n),
		.pin     (ser_din),
		.level   (din_s)
	);

	typedef struct packed
	{
		logic                 sclk_d;
		logic                 en_d;
		logic [WORD_BITS-1:0] shift;
		logic                 dout;
		level_t               lvl1;
		level_t               lvl2;
		logic                 mute1;
		logic                 mute2;
		logic [7:0]           hdb1;
		logic [7:0]           hdb2;
		logic                 latched;
	} ctl_state_t;

	ctl_state_t st_r;
	ctl_state_t st_nxt;

	function automatic chan_sel_t decode_sel(input logic [7:0] sel);
		unique case (sel)
			`SEL_CH1: decode_sel = CH_ONE;
			`SEL_CH2: decode_sel = CH_TWO;
			`SEL_CH3: decode_sel = CH_THREE;
			default:  decode_sel = CH_NONE;
		endcase
	endfunction

	function automatic logic is_mute(input level_t lvl);
		is_mute = (lvl >= `LVL_MUTE_MIN);
	endfunction

	// attenuation in half-dB units; fine range doubles resolution of coarse
	function automatic logic [7:0] half_db(input level_t lvl);
		if (lvl <= `LVL_FINE_MAX)
			half_db = lvl;
		else if (lvl <= `LVL_COARSE_MAX)
			half_db = 8'(`HDB_COARSE_BASE + ((lvl - `LVL_COARSE_MIN) << 1));
		// mute codes report full scale so no reader takes them for a level
		else
			half_db = `HDB_MUTE;
	endfunction

	logic [7:0] sel_byte;
	level_t     lvl_byte;
	chan_sel_t  target;
	logic       sclk_rise;
	logic       en_rise;

	always_comb
	begin
		st_nxt    = st_r;
		sel_byte  = st_r.shift[`SEL_MSB:`SEL_LSB];
		lvl_byte  = st_r.shift[`LVL_MSB:`LVL_LSB];
		target    = decode_sel(sel_byte);
		// edges of filtered levels; reset presets match the idle-high enable
		sclk_rise = sclk_s && !st_r.sclk_d;
		en_rise   = en_n_s && !st_r.en_d;
		st_nxt.sclk_d  = sclk_s;
		st_nxt.en_d    = en_n_s;
		st_nxt.latched = 1'b0;
		// shift only while enabled; msb first lands at the top
		if (sclk_rise && !en_n_s)
		begin
			st_nxt.dout  = st_r.shift[WORD_BITS-1];
			st_nxt.shift = {st_r.shift[WORD_BITS-2:0], din_s};
		end
		// decode the word as it stands; surplus leading bits already left on ser_dout
		if (en_rise)
		begin
			st_nxt.latched = 1'b1;
			// channel 3 code is accepted but drives no ladder here
			unique case (target)
				CH_ONE:
				begin
					st_nxt.lvl1  = lvl_byte;
					st_nxt.mute1 = is_mute(lvl_byte);
					st_nxt.hdb1  = half_db(lvl_byte);
				end
				CH_TWO:
				begin
					st_nxt.lvl2  = lvl_byte;
					st_nxt.mute2 = is_mute(lvl_byte);
					st_nxt.hdb2  = half_db(lvl_byte);
				end
				CH_THREE, CH_NONE: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r         <= '0;
			st_r.sclk_d  <= 1'b1;
			st_r.en_d    <= 1'b1;
			st_r.lvl1    <= `LEVEL_RESET;
			st_r.lvl2    <= `LEVEL_RESET;
			st_r.mute1   <= 1'b1;
			st_r.mute2   <= 1'b1;
			st_r.hdb1    <= `HDB_MUTE;
			st_r.hdb2    <= `HDB_MUTE;
		end
		else
			st_r <= st_nxt;
	end

	assign ser_dout     = st_r.dout;
	assign ch1_level    = st_r.lvl1;
	assign ch2_level    = st_r.lvl2;
	assign ch1_mute     = st_r.mute1;
	assign ch2_mute     = st_r.mute2;
	assign ch1_half_db  = st_r.hdb1;
	assign ch2_half_db  = st_r.hdb2;
	assign word_latched = st_r.latched;

	// decoder and channel state checks
	a_mute_code: assert property (@(posedge clk) disable iff (!reset_n)
		ch1_mute == (ch1_level >= `LVL_MUTE_MIN))
		else $error("channel 1 mute disagrees with level");

	a_reset_mute: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> ch1_mute && ch2_mute)
		else $error("channels not muted after reset");

	a_latch_update: assert property (@(posedge clk) disable iff (!reset_n)
		(en_rise && target == CH_ONE) |=> ch1_level == $past(lvl_byte) && word_latched)
		else $error("channel 1 not updated on latch");

	a_unaddressed_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(en_rise && target == CH_TWO) |=> $stable(ch2_level))
		else $error("channel 2 changed without address");

	// shift path checks, then further decoder, latch and reset checks
	a_shift_gated: assert property (@(posedge clk) disable iff (!reset_n)
		en_n_s && $past(en_n_s) |=> $stable(st_r.shift))
		else $error("shift register moved while disabled");

	a_shift_step: assert property (@(posedge clk) disable iff (!reset_n)
		(sclk_rise && !en_n_s) |=> st_r.shift[0] == $past(din_s)
		&& ser_dout == $past(st_r.shift[WORD_BITS-1]))
		else $error("shift or chain output wrong");

	a_bad_select: assert property (@(posedge clk) disable iff (!reset_n)
		(en_rise && target == CH_NONE) |=> $stable(ch1_level) && $stable(ch2_level))
		else $error("unknown select changed a channel");

	a_coarse_db: assert property (@(posedge clk) disable iff (!reset_n)
		(!ch1_mute && ch1_level >= `LVL_COARSE_MIN)
		|-> ch1_half_db == 8'(ch1_level * 2 - `HDB_COARSE_BASE))
		else $error("coarse attenuation mapping wrong");

	a_ch2_coarse_db: assert property (@(posedge clk) disable iff (!reset_n)
		(!ch2_mute && ch2_level >= `LVL_COARSE_MIN)
		|-> ch2_half_db == 8'(ch2_level * 2 - `HDB_COARSE_BASE))
		else $error("channel 2 coarse attenuation mapping wrong");

	a_ch1_fine_db: assert property (@(posedge clk) disable iff (!reset_n)
		(ch1_level <= `LVL_FINE_MAX) |-> ch1_half_db == ch1_level)
		else $error("channel 1 fine attenuation mapping wrong");

	a_ch2_fine_db: assert property (@(posedge clk) disable iff (!reset_n)
		(ch2_level <= `LVL_FINE_MAX) |-> ch2_half_db == ch2_level)
		else $error("channel 2 fine attenuation mapping wrong");

	a_ch2_mute_code: assert property (@(posedge clk) disable iff (!reset_n)
		ch2_mute == (ch2_level >= `LVL_MUTE_MIN))
		else $error("channel 2 mute disagrees with level");

	a_muted_full_scale: assert property (@(posedge clk) disable iff (!reset_n)
		(!ch1_mute || ch1_half_db == `HDB_MUTE) && (!ch2_mute || ch2_half_db == `HDB_MUTE))
		else $error("muted channel reports a level");

	a_ch1_mute_override: assert property (@(posedge clk) disable iff (!reset_n)
		(en_rise && target == CH_ONE && lvl_byte >= `LVL_MUTE_MIN) |=> ch1_mute)
		else $error("mute code did not mute channel 1");

	a_ch2_mute_override: assert property (@(posedge clk) disable iff (!reset_n)
		(en_rise && target == CH_TWO && lvl_byte >= `LVL_MUTE_MIN) |=> ch2_mute)
		else $error("mute code did not mute channel 2");

	a_ch2_latch: assert property (@(posedge clk) disable iff (!reset_n)
		(en_rise && target == CH_TWO) |=> ch2_level == $past(lvl_byte) && word_latched)
		else $error("channel 2 not updated on latch");

	a_ch1_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(en_rise && target == CH_ONE) |=> $stable(ch1_level) && $stable(ch1_mute) && $stable(ch1_half_db))
		else $error("channel 1 changed without address");

	a_ch2_state_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(en_rise && target == CH_TWO) |=> $stable(ch2_mute) && $stable(ch2_half_db))
		else $error("channel 2 mute or level changed without address");

	a_third_select: assert property (@(posedge clk) disable iff (!reset_n)
		(en_rise && target == CH_THREE) |=> $stable(ch1_level) && $stable(ch2_level) && word_latched)
		else $error("channel 3 select disturbed channels 1 or 2");

	a_pulse_single: assert property (@(posedge clk) disable iff (!reset_n)
		word_latched |=> !word_latched)
		else $error("latch pulse longer than one cycle");

	a_pulse_cause: assert property (@(posedge clk) disable iff (!reset_n)
		word_latched |-> $past(en_rise))
		else $error("latch pulse without enable rise");

	a_latch_no_shift: assert property (@(posedge clk) disable iff (!reset_n)
		en_rise |=> $stable(st_r.shift))
		else $error("shift register moved at latch");

	a_dout_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(sclk_rise && !en_n_s) |=> $stable(ser_dout))
		else $error("chain output moved without a shift");

	a_reset_clear: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> st_r.shift == '0 && !ser_dout && !word_latched)
		else $error("shift path not cleared after reset");

	// main scenarios
	c_ch1_set:  cover property (@(posedge clk) en_rise && target == CH_ONE && !is_mute(lvl_byte));
	c_ch2_mute: cover property (@(posedge clk) en_rise && target == CH_TWO && is_mute(lvl_byte));
	c_ch3_sel:  cover property (@(posedge clk) en_rise && target == CH_THREE);
	c_bad_sel:  cover property (@(posedge clk) en_rise && target == CH_NONE);
	c_shift:    cover property (@(posedge clk) sclk_rise && !en_n_s);
endmodule

// ===== atten_regs.svh
// constants for the serial attenuator control block
// assumes a 50 MHz system clock sampling the three serial lines
`ifndef ATTEN_REGS_SVH
`define ATTEN_REGS_SVH

`define WORD_BITS        16
`define SEL_MSB          15
`define SEL_LSB          8
`define LVL_MSB          7
`define LVL_LSB          0
`define SEL_CH1          8'h00
`define SEL_CH2          8'h01
`define SEL_CH3          8'h02
`define LVL_FINE_MAX     8'h5F
`define LVL_COARSE_MIN   8'h60
`define LVL_COARSE_MAX   8'h7E
`define LVL_MUTE_MIN     8'h7F
`define LEVEL_RESET      8'hFF
`define HDB_MUTE         8'hFF
`define HDB_COARSE_BASE  8'h60
`define CLK_PERIOD_NS    20
`define SETUP_EN_NS      150
`define SETUP_EN_CYC     ((`SETUP_EN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== atten_pkg.sv
// types shared by the attenuator control files
// assumes atten_regs.svh supplies the numeric constants
package atten_pkg;
	typedef enum logic [1:0] {CH_NONE, CH_ONE, CH_TWO, CH_THREE} chan_sel_t;
	typedef logic [7:0] level_t;
endpackage

// ===== pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk
module pin_sync
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// pin and filtered level
	input  wire logic pin,
	output logic      level
);
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.s1  = pin;
		st_nxt.s2  = st_r.s1;
		st_nxt.s3  = st_r.s2;
		// change only when stages two and three agree
		if (st_r.s2 == st_r.s3)
			st_nxt.lvl = st_r.s3;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
		else
			st_r <= st_nxt;
	end

	assign level = st_r.lvl;
endmodule

// ===== atten_host_model.sv
// host model driving the three serial control lines
// assumes clk is the bench clock, used only to pace the lines
module atten_host_model
(
	// pacing clock
	input  wire logic        clk,
	// serial lines
	output logic             ser_clk,
	output logic             ser_en_n,
	output logic             ser_din,
	input  wire logic        ser_dout,
	// bits seen on the chain output
	output logic [31:0]      chain_bits
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		ser_clk = 1'b0;
		ser_en_n = 1'b1;
		ser_din = 1'b0;
		chain_bits = '0;
	end
	// phases of 4 clk or more, since the block samples the lines with clk
	task automatic send(input logic [31:0] w, input int n, input logic en);
		// one edge first, so back-to-back calls never drive a line twice at once
		@(negedge clk);
		ser_en_n <= ~en;
		repeat (8) @(negedge clk);
		for (int i = n - 1; i >= 0; i--)
		begin
			ser_din <= w[i];
			repeat (5) @(negedge clk);
			ser_clk <= 1'b1;
			repeat (5) @(negedge clk);
			ser_clk <= 1'b0;
			repeat (4) @(negedge clk);
			chain_bits <= {chain_bits[30:0], ser_dout};
		end
		ser_en_n <= 1'b1;
		// released data line must not look like held data
		ser_din <= ~ser_din;
	endtask
endmodule

// ===== serial_attenuator_control_tb.sv
// self-checking bench for the serial attenuator control block
// assumes the host model paces the serial lines from clk
`include "atten_regs.svh"
module serial_attenuator_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import atten_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ser_clk, ser_en_n, ser_din, ser_dout, word_latched;
	level_t      ch1_level, ch2_level;
	logic        ch1_mute, ch2_mute;
	logic [7:0]  ch1_half_db, ch2_half_db;
	logic [31:0] chain_bits;
	logic [15:0] sr = '0;
	level_t      lvl[2] = '{8'hFF, 8'hFF};
	level_t      corner[8] = '{8'h00, 8'h5F, 8'h60, 8'h7E, 8'h7F, 8'h80, 8'h3A, 8'hFF};
	int          errors = 0, comparisons = 0, cycles = 0;
	integer      seed = 10571;
	always #10 clk = ~clk;
	atten_host_model atten_host_model_inst (.clk(clk), .ser_clk(ser_clk), .ser_en_n(ser_en_n),
		.ser_din(ser_din), .ser_dout(ser_dout), .chain_bits(chain_bits));
	serial_attenuator_control #(.WORD_BITS(`WORD_BITS)) serial_attenuator_control_inst (.clk(clk),
		.reset_n(reset_n), .ser_clk(ser_clk), .ser_en_n(ser_en_n), .ser_din(ser_din),
		.ser_dout(ser_dout), .ch1_level(ch1_level), .ch1_mute(ch1_mute), .ch2_level(ch2_level),
		.ch2_mute(ch2_mute), .ch1_half_db(ch1_half_db), .ch2_half_db(ch2_half_db),
		.word_latched(word_latched));
	function automatic logic [7:0] half_db(input logic [7:0] c);
		if (c > 8'h7E)
			return 8'hFF;
		if (c > 8'h5F)
			return 8'(8'h60 + 2 * (c - 8'h60));
		return c;
	endfunction
	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_ch();
		check(ch1_level, lvl[0]);
		check(ch1_mute, lvl[0] > 8'h7E);
		check(ch1_half_db, half_db(lvl[0]));
		check(ch2_level, lvl[1]);
		check(ch2_mute, lvl[1] > 8'h7E);
		check(ch2_half_db, half_db(lvl[1]));
	endtask
	// sends n bits, then checks chain output, latch pulse and channels
	task automatic word(input logic [31:0] w, input int n);
		logic [31:0] exp_out;
		int          k;
		exp_out = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			exp_out = {exp_out[30:0], sr[15]};
			sr = {sr[14:0], w[i]};
		end
		atten_host_model_inst.send(w, n, 1'b1);
		k = 0;
		while (word_latched !== 1'b1 && k < 40)
		begin
			@(negedge clk);
			k++;
		end
		check(k < 40, 1);
		check(chain_bits & ((32'h1 << n) - 1), exp_out);
		if (w[15:8] < 8'h02)
			lvl[w[8]] = w[7:0];
		chk_ch();
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			stop_test();
		end
	end
	initial
	begin
		logic [31:0] r;
		repeat (16) @(negedge clk);
		reset_n <= 1'b1;
		repeat (8) @(negedge clk);
		chk_ch();
		check(ser_dout, 0);
		for (int i = 0; i < 8; i++)
			word({16'h0, 8'(i % 2), corner[i]}, 16);
		for (int i = 0; i < 16; i++)
		begin
			r = $random(seed);
			if (i % 4 != 3)
				r[15:8] = 8'(i % 4);
			word(r, (i % 2) ? 24 : 16);
			// clocks with enable high must leave the shift register alone
			atten_host_model_inst.send(~r, 4, 1'b0);
		end
		// reset in mid-run must bring back the power-up state
		reset_n <= 1'b0;
		repeat (2) @(negedge clk);
		reset_n <= 1'b1;
		sr = '0;
		lvl = '{8'hFF, 8'hFF};
		repeat (8) @(negedge clk);
		chk_ch();
		check(ser_dout, 0);
		word({16'h0, 8'h01, 8'h20}, 16);
		stop_test();
	end
endmodule
